// ---- logic/flc_pkg.sv ----
// Purpose: Shared constants and types for the fuse and lock configuration block
// Assumes: Registers sit one per 32-bit word; byte address is four times the index
// Notes:   Lock codes run from least strict (3) to most strict (0)
package flc_pkg;
    // Register indices; byte address is index times four
    localparam logic [3:0] IDX_FUSE4 = 4'h4;
    localparam logic [3:0] IDX_FUSE5 = 4'h5;
    localparam logic [3:0] IDX_LOCK  = 4'h7;
    localparam logic [3:0] IDX_CTRL  = 4'h8;
    localparam logic [3:0] IDX_WDT   = 4'h9;

    // Field positions of the fourth fuse byte
    localparam int FUSE4_RSTDIS_BIT   = 4;
    localparam int FUSE4_STARTUP_LSB  = 2;
    localparam int FUSE4_WATCHDOG_CFG_LOCK_BIT   = 1;
    // Field positions of the fifth fuse byte
    localparam int FUSE5_BROWNOUT_ACTIVE_MODE_LSB   = 4;
    localparam int FUSE5_EEKEEP_BIT   = 3;
    localparam int FUSE5_BODLVL_LSB   = 0;
    localparam logic [7:0] FUSE5_RSVD_MASK = 8'hC0;
    // Field positions of the lock byte
    localparam int LOCK_BOOT_LSB      = 6;
    localparam int LOCK_APP_LSB       = 4;
    localparam int LOCK_TABLE_LSB     = 2;
    localparam int LOCK_EXT_LSB       = 0;
    // Own control and watchdog register bits
    localparam int CTRL_ERASE_BIT     = 0;
    localparam int WDT_EN_BIT         = 0;
    localparam int WDT_WIN_BIT        = 1;

    // Values after reset
    localparam logic [7:0] FUSE4_RST  = 8'hFF;
    localparam logic [7:0] FUSE5_RST  = 8'hFF;
    localparam logic [7:0] LOCK_RST   = 8'hFF;

    // Lock levels
    localparam logic [1:0] LK_UNLOCKED   = 2'h3;
    localparam logic [1:0] LK_WRITE      = 2'h2;
    localparam logic [1:0] LK_READ       = 2'h1;
    localparam logic [1:0] LK_READ_WRITE = 2'h0;

    // Start-up delay selections and lengths in oscillator ticks
    localparam logic [1:0] SEL_64     = 2'h0;
    localparam logic [1:0] SEL_4      = 2'h1;
    localparam logic [1:0] SEL_0      = 2'h3;
    localparam logic [6:0] DLY_CYC_64 = 7'h40;
    localparam logic [6:0] DLY_CYC_4  = 7'h04;
    localparam logic [6:0] DLY_CYC_0  = 7'h00;

    // Brownout modes in active mode
    localparam logic [1:0] BOD_SAMPLED    = 2'h1;
    localparam logic [1:0] BOD_CONTINUOUS = 2'h2;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } flc_seq_t;
endpackage : flc_pkg

// ---- logic/flc_dly_if.sv ----
// Purpose: Carries the start-up delay request between sequencer and counter
// Assumes: One clock domain
// Notes:   hold high restarts the count
`timescale 1ns/1ps
interface flc_dly_if;
    logic       hold;
    logic [1:0] sel;
    logic       done;
    modport ctrl (output hold, output sel, input done);
    modport dly  (input hold, input sel, output done);
endinterface : flc_dly_if

// ---- logic/flc_startup_delay.sv ----
// Purpose: Counts low-power oscillator ticks after all reset sources release
// Assumes: ulp_tick_i is a one-cycle pulse at 1 kHz, synchronous to sys_clk_i
// Notes:   Reserved selection takes the longest delay
`timescale 1ns/1ps
module flc_startup_delay #(
    parameter int CNT_W = 7
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic ulp_tick_i,
    flc_dly_if.dly    dly
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] target;
    logic             done_r;

    always_comb begin
        case (dly.sel)
            flc_pkg::SEL_4:  target = CNT_W'(flc_pkg::DLY_CYC_4);
            flc_pkg::SEL_0:  target = CNT_W'(flc_pkg::DLY_CYC_0);
            default:         target = CNT_W'(flc_pkg::DLY_CYC_64);
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (dly.hold) begin
            cnt_r <= '0;
        end else if (ulp_tick_i && !done_r && cnt_r < target) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
        end else if (dly.hold) begin
            done_r <= 1'b0;
        end else if (cnt_r >= target) begin
            done_r <= 1'b1;
        end
    end

    assign dly.done = done_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    AST_DELAY_LENGTH: assert property (
        $rose(done_r) |-> cnt_r == target)
        else $error("delay ended before the selected tick count");
    AST_ZERO_DELAY: assert property (
        $fell(dly.hold) && dly.sel == flc_pkg::SEL_0 |-> ##1 done_r)
        else $error("zero delay did not end at once");
    AST_FOUR_TICKS: assert property (
        !dly.hold && dly.sel == flc_pkg::SEL_4 && cnt_r < 7'(4) |-> !done_r)
        else $error("four-tick delay ended early");
endmodule : flc_startup_delay

// ---- logic/flc_top.sv ----
// Purpose: Applies fuse and lock configuration to reset, watchdog, brownout, access
// Assumes: Register bus is the programming interface; all inputs synchronous
// Notes:   Fuse and lock copies are reloaded while any reset source is active
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module flc_top #(
    parameter logic [7:0] FUSE5_DEFAULT = flc_pkg::FUSE5_RST
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       ext_reset_n_i,
    input  wire logic       rst_src_i,
    input  wire logic       ulp_tick_i,
    input  wire logic       spm_req_i,
    input  wire logic       lpm_req_i,
    input  wire logic       tgt_boot_i,
    input  wire logic       exec_boot_i,
    input  wire logic       ivec_in_app_i,
    output logic            sys_reset_o,
    output logic            wdt_enable_o,
    output logic            wdt_window_en_o,
    output logic            bod_sampled_o,
    output logic            bod_continuous_o,
    output logic      [2:0] bod_level_o,
    output logic            erase_flash_o,
    output logic            erase_sram_o,
    output logic            erase_eeprom_o,
    output logic            prog_nvm_wr_en_o,
    output logic            prog_read_en_o,
    output logic            acc_grant_o,
    output logic            acc_deny_o,
    output logic            irq_block_o
);
    flc_pkg::flc_seq_t state_r;
    flc_pkg::flc_seq_t state_nxt;

    logic [7:0] fuse4_r;
    logic [7:0] fuse5_r;
    logic [7:0] lock_r;
    logic [7:0] held4_r;
    logic [7:0] held5_r;
    logic [7:0] held_lock_r;
    logic [7:0] rdata_nxt;
    logic [7:0] lock_nxt;
    logic       wdt_en_r;
    logic       wdt_win_r;
    logic       erase_cmd;
    logic       src_active;
    logic       addr_ok;
    logic [3:0] idx;
    logic       fuse_wr_ok;
    logic       read_ok;
    logic [1:0] boot_lk;
    logic [1:0] ext_lk;
    logic       spm_refuse;
    logic       lpm_refuse;

    flc_dly_if dly_if ();

    assign idx     = reg_addr_i[5:2];
    assign addr_ok = (reg_addr_i[1:0] == 2'b00);
    assign boot_lk = held_lock_r[flc_pkg::LOCK_BOOT_LSB +: 2];
    assign ext_lk  = held_lock_r[flc_pkg::LOCK_EXT_LSB +: 2];

    // Reset sources; the pin counts only while its fuse is unprogrammed
    assign src_active = rst_src_i
                      | (~ext_reset_n_i & held4_r[flc_pkg::FUSE4_RSTDIS_BIT]);

    assign erase_cmd = reg_wr_i && addr_ok && idx == flc_pkg::IDX_CTRL
                     && reg_wdata_i[flc_pkg::CTRL_ERASE_BIT];

    // Programming interface gating by the external lock
    assign fuse_wr_ok = (ext_lk == flc_pkg::LK_UNLOCKED);
    assign read_ok    = (ext_lk != flc_pkg::LK_READ_WRITE);

    // Reset sequencer
    always_comb begin
        case (state_r)
            flc_pkg::ST_HOLD:  state_nxt = src_active ? flc_pkg::ST_HOLD : flc_pkg::ST_DELAY;
            flc_pkg::ST_DELAY: begin
                if (src_active) begin
                    state_nxt = flc_pkg::ST_HOLD;
                end else if (dly_if.done) begin
                    state_nxt = flc_pkg::ST_RUN;
                end else begin
                    state_nxt = flc_pkg::ST_DELAY;
                end
            end
            flc_pkg::ST_RUN:   state_nxt = src_active ? flc_pkg::ST_HOLD : flc_pkg::ST_RUN;
            default:           state_nxt = flc_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= flc_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sys_reset_o <= 1'b1;
        end else begin
            sys_reset_o <= (state_nxt != flc_pkg::ST_RUN);
        end
    end

    assign dly_if.hold = (state_r == flc_pkg::ST_HOLD);
    assign dly_if.sel  = held4_r[flc_pkg::FUSE4_STARTUP_LSB +: 2];

    flc_startup_delay #(
        .CNT_W (7)
    ) u_dly (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .ulp_tick_i (ulp_tick_i),
        .dly        (dly_if.dly)
    );

    // Fuse storage written over the programming interface
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fuse4_r <= flc_pkg::FUSE4_RST;
        end else if (reg_wr_i && addr_ok && idx == flc_pkg::IDX_FUSE4 && fuse_wr_ok) begin
            fuse4_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fuse5_r <= FUSE5_DEFAULT | flc_pkg::FUSE5_RSVD_MASK;
        end else if (reg_wr_i && addr_ok && idx == flc_pkg::IDX_FUSE5 && fuse_wr_ok) begin
            fuse5_r <= reg_wdata_i | flc_pkg::FUSE5_RSVD_MASK;
        end
    end

    // Each lock field takes a write only if it is stricter
    always_comb begin
        lock_nxt = lock_r;
        for (int f = 0; f < 4; f++) begin
            if (reg_wdata_i[2*f +: 2] < lock_r[2*f +: 2]) begin
                lock_nxt[2*f +: 2] = reg_wdata_i[2*f +: 2];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_r <= flc_pkg::LOCK_RST;
        end else if (erase_cmd) begin
            lock_r <= flc_pkg::LOCK_RST;
        end else if (reg_wr_i && addr_ok && idx == flc_pkg::IDX_LOCK) begin
            lock_r <= lock_nxt;
        end
    end

    // Held copies follow storage while any reset source is active
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            held4_r     <= flc_pkg::FUSE4_RST;
            held5_r     <= flc_pkg::FUSE5_RST;
            held_lock_r <= flc_pkg::LOCK_RST;
        end else if (state_r == flc_pkg::ST_HOLD) begin
            held4_r     <= fuse4_r;
            held5_r     <= fuse5_r;
            held_lock_r <= lock_r;
        end
    end

    // Watchdog configuration
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_en_r <= 1'b0;
        end else if (state_r != flc_pkg::ST_RUN) begin
            wdt_en_r <= ~held4_r[flc_pkg::FUSE4_WATCHDOG_CFG_LOCK_BIT];
        end else if (reg_wr_i && addr_ok && idx == flc_pkg::IDX_WDT
                     && held4_r[flc_pkg::FUSE4_WATCHDOG_CFG_LOCK_BIT]) begin
            wdt_en_r <= reg_wdata_i[flc_pkg::WDT_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_win_r <= 1'b0;
        end else if (state_r != flc_pkg::ST_RUN) begin
            wdt_win_r <= 1'b0;
        end else if (reg_wr_i && addr_ok && idx == flc_pkg::IDX_WDT) begin
            wdt_win_r <= reg_wdata_i[flc_pkg::WDT_WIN_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wdt_enable_o    <= 1'b0;
            wdt_window_en_o <= 1'b0;
        end else begin
            wdt_enable_o    <= wdt_en_r;
            wdt_window_en_o <= wdt_win_r;
        end
    end

    // Brownout configuration from held copy
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bod_sampled_o    <= 1'b0;
            bod_continuous_o <= 1'b0;
            bod_level_o      <= 3'h7;
        end else begin
            bod_sampled_o    <= held5_r[flc_pkg::FUSE5_BROWNOUT_ACTIVE_MODE_LSB +: 2]
                                == flc_pkg::BOD_SAMPLED;
            bod_continuous_o <= held5_r[flc_pkg::FUSE5_BROWNOUT_ACTIVE_MODE_LSB +: 2]
                                == flc_pkg::BOD_CONTINUOUS;
            bod_level_o      <= held5_r[flc_pkg::FUSE5_BODLVL_LSB +: 3];
        end
    end

    // Chip erase pulses; EEPROM choice uses the live fuse
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            erase_flash_o  <= 1'b0;
            erase_sram_o   <= 1'b0;
            erase_eeprom_o <= 1'b0;
        end else begin
            erase_flash_o  <= erase_cmd;
            erase_sram_o   <= erase_cmd;
            erase_eeprom_o <= erase_cmd & fuse5_r[flc_pkg::FUSE5_EEKEEP_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prog_nvm_wr_en_o <= 1'b1;
            prog_read_en_o   <= 1'b1;
        end else begin
            prog_nvm_wr_en_o <= fuse_wr_ok;
            prog_read_en_o   <= read_ok;
        end
    end

    // Boot section access checks
    assign spm_refuse = tgt_boot_i
                      && (boot_lk == flc_pkg::LK_WRITE || boot_lk == flc_pkg::LK_READ_WRITE);
    assign lpm_refuse = tgt_boot_i && !exec_boot_i
                      && (boot_lk == flc_pkg::LK_READ || boot_lk == flc_pkg::LK_READ_WRITE);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_grant_o <= 1'b0;
            acc_deny_o  <= 1'b0;
        end else begin
            acc_deny_o  <= (spm_req_i && spm_refuse) || (lpm_req_i && lpm_refuse);
            acc_grant_o <= (spm_req_i && !spm_refuse) || (lpm_req_i && !lpm_refuse);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_block_o <= 1'b0;
        end else begin
            irq_block_o <= exec_boot_i && ivec_in_app_i && !boot_lk[1];
        end
    end

    // Register reads; fourth fuse byte shows the copy taken at reset
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd_i && addr_ok) begin
            case (idx)
                flc_pkg::IDX_FUSE4: rdata_nxt = read_ok ? held4_r : 8'h00;
                flc_pkg::IDX_FUSE5: rdata_nxt = read_ok ? fuse5_r : 8'h00;
                flc_pkg::IDX_LOCK:  rdata_nxt = read_ok ? lock_r : 8'h00;
                flc_pkg::IDX_CTRL:  rdata_nxt = {6'h00, state_r};
                flc_pkg::IDX_WDT:   rdata_nxt = {6'h00, wdt_win_r, wdt_en_r};
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_running_locked;
        state_r == flc_pkg::ST_RUN && !held4_r[flc_pkg::FUSE4_WATCHDOG_CFG_LOCK_BIT];
    endsequence

    AST_PIN_IGNORED: assert property (
        state_r == flc_pkg::ST_RUN && !rst_src_i && !held4_r[flc_pkg::FUSE4_RSTDIS_BIT]
        |=> state_r == flc_pkg::ST_RUN)
        else $error("disabled reset pin still caused a reset");
    AST_HELD_STABLE: assert property (
        state_r == flc_pkg::ST_RUN && $past(state_r) == flc_pkg::ST_RUN
        |-> $stable(held4_r) && $stable(held5_r))
        else $error("held configuration changed outside reset");
    AST_RESET_OUT: assert property (
        state_r == flc_pkg::ST_DELAY && !dly_if.done && !src_active |=> sys_reset_o)
        else $error("internal reset released before delay end");
    AST_WDT_FORCED: assert property (
        s_running_locked ##1 state_r == flc_pkg::ST_RUN |-> wdt_en_r)
        else $error("locked watchdog enable not held");
    AST_WIN_SOFT: assert property (
        state_r == flc_pkg::ST_DELAY |=> !wdt_win_r)
        else $error("window enable set without software");
    AST_BOD_MODE: assert property (
        $stable(held5_r) |=> bod_continuous_o == ($past(held5_r[5:4]) == 2'h2)
                             && bod_sampled_o == ($past(held5_r[5:4]) == 2'h1)
                             && bod_level_o == $past(held5_r[2:0]))
        else $error("brownout outputs do not follow held fuse");
    AST_EEPROM_KEEP: assert property (
        erase_cmd |=> erase_flash_o && erase_eeprom_o == $past(fuse5_r[3]))
        else $error("EEPROM erase ignored keep fuse");
    AST_BOOT_STRICT: assert property (
        !$past(erase_cmd) |-> lock_r[7:6] <= $past(lock_r[7:6]))
        else $error("boot lock loosened without erase");
    AST_LOCK_ERASED: assert property (
        erase_cmd |=> lock_r == 8'hFF)
        else $error("chip erase did not unlock");
    AST_SPM_REFUSED: assert property (
        spm_req_i && !lpm_req_i && tgt_boot_i && boot_lk == 2'h2 |=> acc_deny_o && !acc_grant_o)
        else $error("write to write-locked boot section granted");
    AST_LPM_REFUSED: assert property (
        lpm_req_i && !spm_req_i && tgt_boot_i && !exec_boot_i && boot_lk == 2'h1
        |=> acc_deny_o)
        else $error("application read of read-locked boot granted");
    AST_PROG_LOCK: assert property (
        ext_lk == 2'h0 |=> !prog_read_en_o && !prog_nvm_wr_en_o)
        else $error("external lock did not block programming");
endmodule : flc_top

// ---- tb/flc_ulp_model.sv ----
// Purpose: Low-power oscillator stand-in giving one-cycle ticks
// Assumes: Ticks are synchronous to the system clock
// Notes:   Period shortened so the long start-up delay fits the run
`timescale 1ns/1ps
module flc_ulp_model #(
    parameter int PERIOD = 16
) (
    input  wire logic sys_clk_i,
    output logic      tick_o
);
    int cnt_r;
    initial begin
        cnt_r  = 0;
        tick_o = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        cnt_r  <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
        tick_o <= (cnt_r == PERIOD - 1);
    end
endmodule : flc_ulp_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the fuse and lock configuration block
// Assumes: Oscillator ticks come sped up from the partner model
// Notes:   Held copies reload only in reset, so steps reset between them
`timescale 1ns/1ps
module tb_top;
    logic       sys_clk_i, rst_i, reg_wr_i, reg_rd_i, ext_reset_n_i, rst_src_i;
    logic       ulp_tick_i, spm_req_i, lpm_req_i, tgt_boot_i, exec_boot_i, ivec_in_app_i;
    logic [5:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic       sys_reset_o, wdt_enable_o, wdt_window_en_o, bod_sampled_o, bod_continuous_o;
    logic [2:0] bod_level_o;
    logic       erase_flash_o, erase_sram_o, erase_eeprom_o, prog_nvm_wr_en_o;
    logic       prog_read_en_o, acc_grant_o, acc_deny_o, irq_block_o;
    int         fails, cmp_count;

    flc_top i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ext_reset_n_i(ext_reset_n_i), .rst_src_i(rst_src_i),
        .ulp_tick_i(ulp_tick_i), .spm_req_i(spm_req_i), .lpm_req_i(lpm_req_i),
        .tgt_boot_i(tgt_boot_i), .exec_boot_i(exec_boot_i), .ivec_in_app_i(ivec_in_app_i),
        .sys_reset_o(sys_reset_o), .wdt_enable_o(wdt_enable_o),
        .wdt_window_en_o(wdt_window_en_o), .bod_sampled_o(bod_sampled_o),
        .bod_continuous_o(bod_continuous_o), .bod_level_o(bod_level_o),
        .erase_flash_o(erase_flash_o), .erase_sram_o(erase_sram_o),
        .erase_eeprom_o(erase_eeprom_o), .prog_nvm_wr_en_o(prog_nvm_wr_en_o),
        .prog_read_en_o(prog_read_en_o), .acc_grant_o(acc_grant_o),
        .acc_deny_o(acc_deny_o), .irq_block_o(irq_block_o));
    flc_ulp_model i_ulp (.sys_clk_i(sys_clk_i), .tick_o(ulp_tick_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        check(reg_rdata_o, exp);
    endtask : rd

    // Request pulse; expected value is {grant, deny}
    task automatic acc(input logic s, l, t, e, input logic [7:0] exp);
        @(posedge sys_clk_i);
        spm_req_i   <= s;
        lpm_req_i   <= l;
        tgt_boot_i  <= t;
        exec_boot_i <= e;
        @(posedge sys_clk_i);
        spm_req_i   <= 1'b0;
        lpm_req_i   <= 1'b0;
        #1;
        check({6'h00, acc_grant_o, acc_deny_o}, exp);
    endtask : acc

    task automatic erase(input logic [7:0] exp);
        wr(6'h20, 8'h01);
        #1;
        check({5'h00, erase_flash_o, erase_sram_o, erase_eeprom_o}, exp);
    endtask : erase

    // Pulse a reset source released right after a tick, count ticks of the delay
    task automatic do_rst(input logic [7:0] exp_ticks);
        int         n;
        logic [7:0] tk;
        n  = 0;
        tk = 8'h00;
        @(posedge sys_clk_i);
        rst_src_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        while (ulp_tick_i !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 100) begin
            fails++;
            tally_and_finish();
        end
        rst_src_i <= 1'b0;
        n = 0;
        while (sys_reset_o === 1'b1 && n < 2000) begin
            @(posedge sys_clk_i);
            if (ulp_tick_i === 1'b1 && sys_reset_o === 1'b1)
                tk++;
            n++;
        end
        if (n >= 2000) begin
            fails++;
            tally_and_finish();
        end else begin
            check(tk, exp_ticks);
        end
    endtask : do_rst

    task automatic pin(input logic exp);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        ext_reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        check({7'h00, sys_reset_o}, {7'h00, exp});
        @(posedge sys_clk_i);
        ext_reset_n_i <= 1'b1;
        while (sys_reset_o !== 1'b0 && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            tally_and_finish();
        end
    endtask : pin

    task automatic wdt(input logic [7:0] d, input logic [7:0] exp);
        wr(6'h24, d);
        repeat (2) @(posedge sys_clk_i);
        #1;
        check({6'h00, wdt_enable_o, wdt_window_en_o}, exp);
    endtask : wdt

    initial begin
        logic [7:0] f5 [3];
        f5 = '{8'hD5, 8'hE2, 8'hF8};
        fails = 0;
        cmp_count = 0;
        {reg_wr_i, reg_rd_i, rst_src_i, spm_req_i, lpm_req_i} = 5'h00;
        {tgt_boot_i, exec_boot_i, ivec_in_app_i} = 3'h0;
        reg_addr_i = 6'h00;
        reg_wdata_i = 8'h00;
        ext_reset_n_i = 1'b1;
        rst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        do_rst(8'h00);
        rd(6'h20, 8'h02);
        rd(6'h1C, 8'hFF);
        rd(6'h14, 8'hFF);
        rd(6'h2C, 8'h00);
        rd(6'h1D, 8'h00);
        check({bod_sampled_o, bod_continuous_o, bod_level_o, prog_nvm_wr_en_o,
               prog_read_en_o, 1'b0}, 8'h3E);
        wdt(8'h01, 8'h02);
        wdt(8'h00, 8'h00);
        pin(1'b1);
        $display("test reset_defaults done");
        for (int i = 0; i < 3; i++) begin
            wr(6'h14, f5[i]);
            rd(6'h14, f5[i]);
            erase({7'h03, f5[i][flc_pkg::FUSE5_EEKEEP_BIT]});
            do_rst(8'h00);
            check({bod_sampled_o, bod_continuous_o, 3'h0, bod_level_o},
                  {f5[i][5:4] == 2'b01, f5[i][5:4] == 2'b10, 3'h0, f5[i][2:0]});
        end
        $display("test brownout_eeprom done");
        wr(6'h10, 8'hF3);
        rd(6'h10, 8'hFF);
        do_rst(8'h40);
        wr(6'h10, 8'hE5);
        rd(6'h10, 8'hF3);
        do_rst(8'h04);
        rd(6'h10, 8'hE5);
        wdt(8'h00, 8'h02);
        wdt(8'h02, 8'h03);
        rd(6'h24, 8'h03);
        pin(1'b0);
        wr(6'h10, 8'hFF);
        do_rst(8'h00);
        $display("test startup_watchdog done");
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h02);
        wr(6'h1C, 8'hBF);
        rd(6'h1C, 8'hBF);
        do_rst(8'h00);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h01);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 8'h02);
        wr(6'h1C, 8'hFF);
        rd(6'h1C, 8'hBF);
        wr(6'h1C, 8'h7F);
        do_rst(8'h00);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h02);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 8'h01);
        acc(1'b0, 1'b1, 1'b1, 1'b1, 8'h02);
        @(posedge sys_clk_i);
        ivec_in_app_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        check({7'h00, irq_block_o}, 8'h01);
        @(posedge sys_clk_i);
        ivec_in_app_i <= 1'b0;
        wr(6'h1C, 8'h3F);
        do_rst(8'h00);
        acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h01);
        acc(1'b0, 1'b1, 1'b1, 1'b0, 8'h01);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 8'h02);
        erase(8'h07);
        rd(6'h1C, 8'hFF);
        $display("test boot_lock done");
        wr(6'h1C, 8'hFE);
        do_rst(8'h00);
        check({6'h00, prog_nvm_wr_en_o, prog_read_en_o}, 8'h01);
        wr(6'h14, 8'hD5);
        rd(6'h14, 8'hF8);
        wr(6'h1C, 8'hFC);
        do_rst(8'h00);
        check({6'h00, prog_nvm_wr_en_o, prog_read_en_o}, 8'h00);
        rd(6'h1C, 8'h00);
        erase(8'h07);
        do_rst(8'h00);
        check({6'h00, prog_nvm_wr_en_o, prog_read_en_o}, 8'h03);
        $display("test external_lock done");
        tally_and_finish();
    end
endmodule : tb_top
